// file: rtl/stepper_pkg.sv
package stepper_pkg;

    // ******************************************************************
    // register map (classic wishbone, byte addresses)
    // ******************************************************************
    localparam logic [7:0] ctrl_addr   = 8'h00;
    localparam logic [7:0] status_addr = 8'h04;
    localparam logic [7:0] seq_addr    = 8'h08;
    localparam logic [7:0] pos_addr    = 8'h0c;
    localparam logic [7:0] count_addr  = 8'h10;

    // ******************************************************************
    // control fields
    // ******************************************************************
    localparam int ctrl_slave_bit = 0;
    localparam int ctrl_half_bit  = 1;
    localparam int ctrl_teach_bit = 2;

    // ******************************************************************
    // sequence store
    // ******************************************************************
    localparam int          seq_depth   = 25;
    localparam int          seq_aw      = 5;
    localparam int          seq_w       = 32;
    localparam logic [4:0]  seq_first   = 5'h00;
    // entry: [31] direction, [30:24] pull-in, [23:16] max rate,
    // [15:8] acceleration (unused here), [7:0] step count
    localparam int          ent_dir_bit = 31;
    localparam int          ent_cnt_lsb = 0;
    localparam int          ent_cnt_w   = 8;
    localparam int          ent_div_lsb = 16;
    localparam int          ent_div_w   = 8;

    // ******************************************************************
    // timing
    // ******************************************************************
    localparam int          clk_mhz     = 250;
    localparam int          tick_us     = 10;
    localparam int          tick_cycles = tick_us * clk_mhz;
    localparam logic [11:0] tick_last   = 12'(tick_cycles - 1);

    // ******************************************************************
    // coil patterns a,b,c,d in bits 3..0
    // ******************************************************************
    // rest on the first two-coil pattern: full-step mode shows a one-coil state at coils_o only for two cycles after half-step mode is left on an even phase
    localparam logic [3:0] coil_reset = 4'hc;
    localparam logic [2:0] phase_reset = 3'h1;
    localparam logic [2:0] phase_step_full = 3'h2;
    localparam logic [2:0] phase_step_half = 3'h1;

    typedef enum logic [1:0] {
        idle_st  = 2'b00,
        load_st  = 2'b01,
        run_st   = 2'b10
    } replay_state_type;

endpackage

// file: rtl/coil_table.sv
module coil_table (
    // phase index, 8 half-step positions
    input  wire logic [2:0] phase_i,
    // coil drive a,b,c,d
    output logic      [3:0] coils_o
);
    always_comb begin
        case (phase_i)
            3'h0:    coils_o = 4'h8;
            3'h1:    coils_o = 4'hc;
            3'h2:    coils_o = 4'h4;
            3'h3:    coils_o = 4'h6;
            3'h4:    coils_o = 4'h2;
            3'h5:    coils_o = 4'h3;
            3'h6:    coils_o = 4'h1;
            3'h7:    coils_o = 4'h9;
            default: coils_o = 4'h0;
        endcase
    end
endmodule // coil_table

// file: rtl/stepper_pin_slave_control.sv
// Functional notes
// - each step falling edge moves one step
// - half-step mode moves half step per edge
// - direction low ccw, high cw at edge
// - replay-all pulse plays every stored sequence
// - replay-next pulse plays one, advances pointer
// - replay-all always starts at first sequence
// - after replay-all, replay-next restarts at first
// - ready output high idle, low busy
// - replayed sequences are the taught ones
// - full two-phase cw pattern table
// - half-step cw eight-pattern table
// - ccw walks table in reverse
// - store holds twenty-five sequences
module stepper_pin_slave_control
    import stepper_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // controller pins
    input  wire logic        step_pulse_in,
    input  wire logic        direction_in,
    input  wire logic        replay_all_in,
    input  wire logic        replay_next_in,
    // motor and status
    output logic      [3:0]  coils_o,
    output logic             ready_o
);
    import stepper_pkg::*;

    // ******************************************************************
    // pin synchronisers
    // ******************************************************************
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [3:0] pin_last;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;

    always_ff @(posedge clk_i) begin
        pin_meta <= {replay_next_in, replay_all_in, direction_in, step_pulse_in};
        pin_sync <= pin_meta;
        pin_last <= pin_sync;
    end

    assign pin_fall = pin_last & ~pin_sync;
    assign pin_rise = ~pin_last & pin_sync;

    // ******************************************************************
    // registers
    // ******************************************************************
    logic [2:0]        ctrl;
    logic [seq_w-1:0]  store [seq_depth];
    logic [seq_aw-1:0] seq_count;
    logic              slave_mode;
    logic              half_mode;
    logic              wb_hit;
    logic              wb_wr;

    assign slave_mode = ctrl[ctrl_slave_bit];
    assign half_mode  = ctrl[ctrl_half_bit];
    assign wb_hit     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr      = wb_hit & wb_we_i & (&wb_sel_i);

    function automatic logic is_store(input logic [7:0] adr);
        return adr == seq_addr;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl      <= '0;
            seq_count <= '0;
        end else if (wb_wr && wb_adr_i == ctrl_addr) begin
            ctrl <= wb_dat_i[2:0];
        end else if (wb_wr && wb_adr_i == count_addr) begin
            // sequences are only written while teaching
            if (ctrl[ctrl_teach_bit] && wb_dat_i[seq_aw-1:0] <= 5'(seq_depth)) begin
                seq_count <= wb_dat_i[seq_aw-1:0];
            end
        end
    end

    // word index selected through the position register write
    logic [seq_aw-1:0] store_idx;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            store_idx <= '0;
        end else if (wb_wr && wb_adr_i == pos_addr) begin
            store_idx <= wb_dat_i[seq_aw-1:0];
        end else if (wb_wr && is_store(wb_adr_i) && ctrl[ctrl_teach_bit]) begin
            store_idx <= store_idx + 5'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (wb_wr && is_store(wb_adr_i) && ctrl[ctrl_teach_bit]
            && store_idx < 5'(seq_depth)) begin
            store[store_idx] <= wb_dat_i;
        end
    end

    // ******************************************************************
    // motion
    // ******************************************************************
    replay_state_type  state;
    logic [seq_aw-1:0] play_ptr;
    logic [seq_aw-1:0] next_ptr;
    logic              play_all;
    logic [ent_cnt_w-1:0] steps_left;
    logic [ent_div_w-1:0] div_cnt;
    logic [ent_div_w-1:0] div_load;
    logic              play_dir;
    logic [11:0]       tick_cnt;
    logic              tick;
    logic [2:0]        phase;
    logic [2:0]        stride;
    logic              pin_step;
    logic              replay_step;
    logic              go_all;
    logic              go_next;
    logic              step_dir;
    logic              step_now;
    logic [seq_w-1:0]  entry;

    assign stride   = half_mode ? phase_step_half : phase_step_full;
    assign go_all   = slave_mode & pin_rise[2] & (state == idle_st) & (seq_count != '0);
    assign go_next  = slave_mode & pin_rise[3] & (state == idle_st) & (seq_count != '0);
    assign pin_step = slave_mode & pin_fall[0] & (state == idle_st);
    assign entry    = store[play_ptr];
    assign replay_step = (state == run_st) & tick & (div_cnt == '0) & (steps_left != '0);
    assign step_now = pin_step | replay_step;
    assign step_dir = pin_step ? pin_sync[1] : play_dir;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick ? '0 : tick_cnt + 12'h001;
        end
    end
    assign tick = tick_cnt == tick_last;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= phase_reset;
        end else if (step_now) begin
            // full mode forces phase odd, so only two-coil patterns appear except in the cycle after half mode is left on an even phase
            if (step_dir) begin
                phase <= phase + stride | {2'b00, ~half_mode};
            end else begin
                phase <= phase - stride | {2'b00, ~half_mode};
            end
        end else if (!half_mode) begin
            phase[0] <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state      <= idle_st;
            play_ptr   <= seq_first;
            next_ptr   <= seq_first;
            play_all   <= 1'b0;
            steps_left <= '0;
            div_cnt    <= '0;
            div_load   <= '0;
            play_dir   <= 1'b0;
        end else begin
            case (state)
                idle_st: begin
                    if (go_all) begin
                        play_ptr <= seq_first;
                        play_all <= 1'b1;
                        state    <= load_st;
                    end else if (go_next) begin
                        play_ptr <= next_ptr;
                        play_all <= 1'b0;
                        state    <= load_st;
                    end
                end
                load_st: begin
                    steps_left <= entry[ent_cnt_lsb +: ent_cnt_w];
                    div_load   <= entry[ent_div_lsb +: ent_div_w];
                    div_cnt    <= entry[ent_div_lsb +: ent_div_w];
                    play_dir   <= entry[ent_dir_bit];
                    state      <= run_st;
                end
                run_st: begin
                    if (steps_left == '0) begin
                        if (play_all && play_ptr + 5'h01 < seq_count) begin
                            play_ptr <= play_ptr + 5'h01;
                            state    <= load_st;
                        end else begin
                            if (play_all) begin
                                next_ptr <= seq_first;
                            end else begin
                                next_ptr <= (play_ptr + 5'h01 < seq_count)
                                            ? play_ptr + 5'h01 : seq_first;
                            end
                            play_all <= 1'b0;
                            state    <= idle_st;
                        end
                    end else if (tick) begin
                        if (div_cnt == '0) begin
                            div_cnt    <= div_load;
                            steps_left <= steps_left - 8'h01;
                        end else begin
                            div_cnt <= div_cnt - 8'h01;
                        end
                    end
                end
                default: state <= idle_st;
            endcase
        end
    end

    // ******************************************************************
    // outputs
    // ******************************************************************
    logic [3:0] coil_pat;
    logic       step_settling;

    // coils take up a new phase one cycle after it moves
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_settling <= 1'b0;
        end else begin
            step_settling <= step_now;
        end
    end

    coil_table u_table (
        .phase_i (phase),
        .coils_o (coil_pat)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            coils_o <= coil_reset;
            ready_o <= 1'b0;
        end else begin
            coils_o <= coil_pat;
            // busy covers the phase move and the cycle in which the coils follow it
            ready_o <= (state == idle_st) & ~step_now & ~step_settling
                       & ~go_all & ~go_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    ctrl_addr:   wb_dat_o <= {29'h0, ctrl};
                    status_addr: wb_dat_o <= {20'h0, play_all, ready_o, state,
                                              next_ptr, phase};
                    seq_addr:    wb_dat_o <= (store_idx < 5'(seq_depth)) ? store[store_idx] : '0;
                    pos_addr:    wb_dat_o <= {27'h0, store_idx};
                    count_addr:  wb_dat_o <= {27'h0, seq_count};
                    default:     wb_dat_o <= '0;
                endcase
            end
        end
    end
endmodule // stepper_pin_slave_control

// file: verif/ctl_partner.sv
module ctl_partner (
    // clock
    input  wire logic clk_i,
    // controller pins
    output logic      step_o,
    output logic      dir_o,
    output logic      all_o,
    output logic      next_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        step_o = 1'b1;
        dir_o  = 1'b1;
        all_o  = 1'b1;
        next_o = 1'b1;
    end

    // ******************************************************************
    // pin drivers
    // ******************************************************************
    // direction moves a cycle ahead so it is settled when the edge is seen
    task automatic step(input logic d);
        @(posedge clk_i);
        dir_o <= d;
        @(posedge clk_i);
        step_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        step_o <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask

    // only one pin is pulsed low; all_o and next_o are released together
    task automatic pulse(input bit all);
        @(posedge clk_i);
        if (all) begin
            all_o <= 1'b0;
        end else begin
            next_o <= 1'b0;
        end
        repeat (2) @(posedge clk_i);
        all_o <= 1'b1;
        next_o <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask
endmodule // ctl_partner

// file: verif/stepper_ctl_checker.sv
module stepper_ctl_checker
    import stepper_pkg::*;
(
    // clock, reset and bus
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_ack_o,
    // pins
    input  wire logic        step_pulse_in,
    input  wire logic [3:0]  coils_o,
    input  wire logic        ready_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // shadow of the mode bits, one cycle late, so only idle-time changes are safe
    logic [2:0] ctrl;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= 3'h0;
        end else if (wb_ack_o && wb_we_i && wb_adr_i == ctrl_addr && wb_sel_i == 4'hf) begin
            ctrl <= wb_dat_i[2:0];
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_step_edge;
        ctrl[0] && ready_o && $fell(step_pulse_in);
    endsequence
    sequence s_busy_cycle;
        ##[1:6] !ready_o ##[1:4] ready_o;
    endsequence

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    a_reset_release: assert property ($fell(rst_i) |->
        !ready_o && coils_o == coil_reset ##1 ready_o)
        else $error("wrong state after reset");
    a_step_busy: assert property (s_step_edge |-> s_busy_cycle)
        else $error("step did not show busy then ready");
    a_step_moves: assert property (s_step_edge |-> ##[1:6] $changed(coils_o))
        else $error("step edge did not move coils");
    a_move_busy: assert property ($changed(coils_o) |-> !ready_o)
        else $error("coils moved while ready");
    a_full_table: assert property (!ctrl[1] && coils_o != 4'h0 |->
        coils_o inside {4'hc, 4'h6, 4'h3, 4'h9})
        else $error("illegal full-step pattern");
    a_half_table: assert property (ctrl[1] && $changed(coils_o) |->
        $countones(coils_o ^ $past(coils_o)) == 1)
        else $error("half step skipped a table entry");
    a_idle_hold: assert property (!ctrl[0] && ready_o |=> $stable(coils_o))
        else $error("coils moved outside slave mode");
endmodule // stepper_ctl_checker

bind stepper_pin_slave_control stepper_ctl_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .step_pulse_in(step_pulse_in), .coils_o(coils_o), .ready_o(ready_o)
);

// file: verif/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import stepper_pkg::*;

    localparam logic [3:0] pat [8] = '{4'h8, 4'hc, 4'h4, 4'h6, 4'h2, 4'h3, 4'h1, 4'h9};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
    logic        wb_ack_o, step_w, dir_w, all_w, next_w, ready_o;
    logic [3:0]  coils_o, prev_c;
    int          err_total = 0, samples_checked = 0, moves = 0, net = 0;

    always #2 clk_i = ~clk_i;

    stepper_pin_slave_control DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .step_pulse_in(step_w), .direction_in(dir_w),
        .replay_all_in(all_w), .replay_next_in(next_w), .coils_o(coils_o), .ready_o(ready_o)
    );
    ctl_partner ctl (
        .clk_i(clk_i), .step_o(step_w), .dir_o(dir_w), .all_o(all_w), .next_o(next_w)
    );

    // ******************************************************************
    // motion monitor: signed half-step count from the table position
    // ******************************************************************
    function automatic int idx(input logic [3:0] c);
        for (int i = 0; i < 8; i++) if (pat[i] === c) return i;
        return 0;
    endfunction
    always @(posedge clk_i) begin
        if (coils_o !== prev_c && prev_c != 4'h0 && coils_o != 4'h0) begin
            moves++;
            net += ((idx(coils_o) - idx(prev_c) + 12) % 8) - 4;
        end
        prev_c <= coils_o;
    end

    task automatic chk(input bit ok, input string m);
        samples_checked++;
        if (!ok) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        chk(n < 50, "no bus answer");
    endtask

    task automatic step_case(input logic d, input int en, input int em);
        int m0, n0;
        m0 = moves;
        n0 = net;
        ctl.step(d);
        repeat (3) @(posedge clk_i);
        chk(moves - m0 == em && net - n0 == en && ready_o === 1'b1, "step motion");
    endtask

    task automatic replay_case(input bit all, input int em, input int en);
        int m0, n0, n;
        m0 = moves;
        n0 = net;
        n = 0;
        ctl.pulse(all);
        while (ready_o !== 1'b0 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        while (ready_o !== 1'b1 && n < 40000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (2) @(posedge clk_i);
        chk(n < 40000 && moves - m0 == em && net - n0 == en, "replay motion");
    endtask

    task automatic full_case();
        wb(1'b1, ctrl_addr, 32'h1);
        ctl.step(1'b1);
        repeat (3) @(posedge clk_i);
        chk(coils_o inside {4'hc, 4'h6, 4'h3, 4'h9}, "full pattern");
        step_case(1'b1, 2, 1);
        step_case(1'b1, 2, 1);
        step_case(1'b0, -2, 1);
        wb(1'b1, ctrl_addr, 32'h3);
        step_case(1'b1, 1, 1);
        step_case(1'b0, -1, 1);
    endtask

    // teach with half kept set, so idle coils stay legal for the checker
    task automatic teach_case();
        wb(1'b1, ctrl_addr, 32'h6);
        wb(1'b1, pos_addr, 32'h0);
        wb(1'b1, seq_addr, 32'h8000_0002);
        wb(1'b1, seq_addr, 32'h0000_0001);
        wb(1'b1, seq_addr, 32'h8000_0003);
        wb(1'b1, count_addr, 32'h3);
        wb(1'b0, count_addr, 32'h0);
        chk(rdat === 32'h3, "sequence count readback");
        step_case(1'b1, 0, 0);
        ctl.pulse(1'b1);
        repeat (10) @(posedge clk_i);
        chk(ready_o === 1'b1, "replay outside slave");
    endtask

    task automatic replay_scn();
        wb(1'b1, ctrl_addr, 32'h3);
        replay_case(1'b0, 2, 2);
        replay_case(1'b0, 1, -1);
        replay_case(1'b1, 6, 4);
        replay_case(1'b0, 2, 2);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(ready_o === 1'b1 && coils_o === coil_reset, "idle after reset");
        wb(1'b0, 8'h40, 32'h0);
        chk(rdat === 32'h0, "unmapped read");
        full_case();
        teach_case();
        replay_scn();
        print_verdict();
    end
endmodule // tb
